// ===== hw/sae_addr_gen.sv
// Target-address generator for a byte-oriented instruction operand.
// Assumes the indexed base arrives from the core's pointer register.
module sae_addr_gen (
   input sae_pkg::sae_opnd_t opnd,
   input wire logic ext_en,
   input wire logic [3:0] bank_select_reg,
   input wire logic [11:0] index_base,
   output logic [11:0] addr,
   output logic indexed
);
   // Access bank splits into a low and a high window
   always_comb begin
      indexed = 1'b0;
      if (opnd.a) begin
         addr = {bank_select_reg, opnd.f};
      end else if (ext_en && opnd.f <= sae_pkg::LIT_OFS_MAX) begin
         addr = index_base + {4'h0, opnd.f};
         indexed = 1'b1;
      end else if (opnd.f <= sae_pkg::LIT_OFS_MAX) begin
         addr = {sae_pkg::ACCESS_LO_BANK, opnd.f};
      end else begin
         addr = {sae_pkg::ACCESS_HI_BANK, opnd.f};
      end
   end
endmodule

// ===== hw/sae_exec.sv
// Execution unit for the set-all-ones and sleep instructions, with APB registers.
// Assumes data memory answers writes in one pclk and the watchdog clears on a pulse.
//
// Functional notes
// - Set-all writes FFh to the addressed register and touches no arithmetic flag.
// - Set-all with access bit 0 uses the access bank, with 1 uses the bank select register.
// - Extended set on, access bit 0 and operand at most 95 selects indexed literal-offset addressing.
// - Sleep clears the power-down flag.
// - Sleep sets the time-out flag.
// - Sleep clears the watchdog count to 00h and its postscaler.
// - Sleep halts the oscillator in the fourth quarter and reads no operand in the second.
// - A wake-up caused by the watchdog clears the time-out flag.
//
// Implementation choices: the register offsets and the APB slave port.
module sae_exec #(
   parameter int QDIV = sae_pkg::QDIV_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [11:0] index_base,
   input wire logic wake_req,
   input wire logic wake_by_wdt,
   output sae_pkg::sae_mem_req_t mem_req,
   output logic wdt_clr,
   output logic osc_run,
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic irq
);
   typedef struct packed {
      sae_pkg::sae_st_t st;
      logic [15:0] instr;
      logic pending;
      logic ext_en;
      logic [3:0] bank;
      logic tmo;
      logic pdn;
      logic [sae_pkg::NUM_EV-1:0] istat;
      logic [sae_pkg::NUM_EV-1:0] imask;
      logic [31:0] rdata;
      logic err;
      sae_pkg::sae_mem_req_t mem;
      logic wdt_clr;
      logic osc_run;
   } sae_state_t;

   sae_state_t s_q, s_d;
   sae_pkg::sae_q_t q_phase;
   logic q_tick;
   logic [11:0] tgt_addr;
   logic tgt_indexed;
   logic setup, wr_acc;
   logic [sae_pkg::NUM_EV-1:0] ev;

   // Decode helpers, used by the dispatch and the quarter-phase execution
   function automatic logic is_set_all(input logic [15:0] w);
      return w[15:9] == sae_pkg::SET_ALL_OPC;
   endfunction

   function automatic logic is_sleep(input logic [15:0] w);
      return w == sae_pkg::SLEEP_OPC;
   endfunction

   function automatic logic known_op(input logic [15:0] w);
      return is_set_all(w) || is_sleep(w);
   endfunction

   // Quarter phases stop while the oscillator is halted
   sae_qgen #(
      .QDIV(QDIV)
   ) u_qgen (
      .pclk(pclk),
      .presetn(presetn),
      .run(s_q.osc_run),
      .q_phase(q_phase),
      .q_tick(q_tick)
   );

   // Operand address for the latched instruction word
   sae_addr_gen u_addr (
      .opnd(sae_pkg::sae_opnd_t'(s_q.instr[8:0])),
      .ext_en(s_q.ext_en),
      .bank_select_reg(s_q.bank),
      .index_base(index_base),
      .addr(tgt_addr),
      .indexed(tgt_indexed)
   );

   // APB phases: data is sampled in setup so the access phase needs no wait
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign pready = 1'b1;
   assign prdata = s_q.rdata;
   assign pslverr = psel & penable & s_q.err;

   // Outputs straight from state
   assign mem_req = s_q.mem;
   assign wdt_clr = s_q.wdt_clr;
   assign osc_run = s_q.osc_run;
   assign timeout_flag = s_q.tmo;
   assign powerdown_flag = s_q.pdn;
   assign irq = |(s_q.istat & s_q.imask);

   // Next state: bus slave, dispatcher, quarter-phase execution, sleep
   always_comb begin
      s_d = s_q;
      ev = '0;
      s_d.mem.rd = 1'b0;
      s_d.mem.wr = 1'b0;
      s_d.wdt_clr = 1'b0;

      // Register read captured in setup, unmapped offsets flag an error
      if (setup) begin
         s_d.rdata = 32'h0000_0000;
         s_d.err = 1'b0;
         unique case (paddr)
            sae_pkg::CTRL_OFS: s_d.rdata[sae_pkg::CTRL_EXT_BIT] = s_q.ext_en;
            sae_pkg::BANK_OFS: s_d.rdata[3:0] = s_q.bank;
            sae_pkg::INSTR_OFS: s_d.rdata[15:0] = s_q.instr;
            sae_pkg::FLAGS_OFS: begin
               s_d.rdata[sae_pkg::FLAG_TMO_BIT] = s_q.tmo;
               s_d.rdata[sae_pkg::FLAG_PDN_BIT] = s_q.pdn;
               s_d.rdata[sae_pkg::FLAG_SLEEP_BIT] = (s_q.st == sae_pkg::SAE_SLEEP);
               s_d.rdata[sae_pkg::FLAG_BUSY_BIT] = (s_q.st == sae_pkg::SAE_EXEC);
               s_d.rdata[sae_pkg::FLAG_PEND_BIT] = s_q.pending;
            end
            sae_pkg::ISTAT_OFS: s_d.rdata[sae_pkg::NUM_EV-1:0] = s_q.istat;
            sae_pkg::IMASK_OFS: s_d.rdata[sae_pkg::NUM_EV-1:0] = s_q.imask;
            default: s_d.err = 1'b1;
         endcase
      end

      // Register writes take effect in the access phase
      if (wr_acc) begin
         unique case (paddr)
            sae_pkg::CTRL_OFS: s_d.ext_en = pwdata[sae_pkg::CTRL_EXT_BIT];
            sae_pkg::BANK_OFS: s_d.bank = pwdata[3:0];
            sae_pkg::INSTR_OFS: begin
               // A word already queued or running is not overwritten
               if (!s_q.pending && s_q.st == sae_pkg::SAE_IDLE) begin
                  s_d.instr = pwdata[15:0];
                  s_d.pending = 1'b1;
               end
            end
            sae_pkg::IMASK_OFS: s_d.imask = pwdata[sae_pkg::NUM_EV-1:0];
            default: ;
         endcase
      end

      // Instruction cycle driven by quarter-phase ticks
      unique case (s_q.st)
         sae_pkg::SAE_IDLE: begin
            // Start only at a cycle boundary, so every instruction gets full Q1..Q4
            if (q_tick && q_phase == sae_pkg::SAE_Q4 && s_q.pending) begin
               s_d.pending = 1'b0;
               if (known_op(s_q.instr)) begin
                  s_d.st = sae_pkg::SAE_EXEC;
               end else begin
                  ev[sae_pkg::EV_ILLEGAL] = 1'b1;
               end
            end
         end
         sae_pkg::SAE_EXEC: begin
            if (q_tick) begin
               unique case (q_phase)
                  sae_pkg::SAE_Q1: begin
                     // Entering Q2: operand read for set-all, none for sleep
                     if (is_set_all(s_q.instr)) begin
                        s_d.mem.addr = tgt_addr;
                        s_d.mem.indexed = tgt_indexed;
                        s_d.mem.rd = 1'b1;
                     end
                  end
                  sae_pkg::SAE_Q2: ;
                  sae_pkg::SAE_Q3: begin
                     // Entering Q4: write back or go to sleep
                     if (is_set_all(s_q.instr)) begin
                        s_d.mem.wdata = sae_pkg::ALL_ONES;
                        s_d.mem.wr = 1'b1;
                     end else begin
                        s_d.wdt_clr = 1'b1;
                        s_d.tmo = 1'b1;
                        s_d.pdn = 1'b0;
                        s_d.osc_run = 1'b0;
                        s_d.st = sae_pkg::SAE_SLEEP;
                        ev[sae_pkg::EV_SLEEP] = 1'b1;
                     end
                  end
                  sae_pkg::SAE_Q4: begin
                     s_d.st = sae_pkg::SAE_IDLE;
                     ev[sae_pkg::EV_SET_ALL] = 1'b1;
                  end
               endcase
            end
         end
         sae_pkg::SAE_SLEEP: begin
            // Quarter phases are frozen; only a wake request restarts them
            if (wake_req) begin
               s_d.osc_run = 1'b1;
               s_d.st = sae_pkg::SAE_IDLE;
               ev[sae_pkg::EV_WAKE] = 1'b1;
               if (wake_by_wdt) begin
                  s_d.tmo = 1'b0;
               end
            end
         end
         default: s_d.st = sae_pkg::SAE_IDLE;
      endcase

      // Write-one-to-clear; a new event in the same cycle wins
      if (wr_acc && paddr == sae_pkg::ISTAT_OFS) begin
         s_d.istat = s_q.istat & ~pwdata[sae_pkg::NUM_EV-1:0];
      end
      s_d.istat = s_d.istat | ev;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{
            st: sae_pkg::SAE_IDLE,
            instr: sae_pkg::INSTR_RST,
            pending: 1'b0,
            ext_en: sae_pkg::CTRL_EXT_RST,
            bank: sae_pkg::BANK_RST,
            tmo: sae_pkg::TMO_RST,
            pdn: sae_pkg::PDN_RST,
            istat: '0,
            imask: '0,
            rdata: 32'h0000_0000,
            err: 1'b0,
            mem: '0,
            wdt_clr: 1'b0,
            osc_run: 1'b1
         };
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ===== hw/sae_pkg.sv
// Package for the set-all / sleep execution block: offsets, fields, codes, types.
// Assumes a 32-bit APB slave with byte addresses and a 12-bit data-memory address.
package sae_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] BANK_OFS = 8'h04;
   localparam logic [7:0] INSTR_OFS = 8'h08;
   localparam logic [7:0] FLAGS_OFS = 8'h0c;
   localparam logic [7:0] ISTAT_OFS = 8'h10;
   localparam logic [7:0] IMASK_OFS = 8'h14;

   // Field positions
   localparam int CTRL_EXT_BIT = 0;
   localparam int FLAG_TMO_BIT = 0;
   localparam int FLAG_PDN_BIT = 1;
   localparam int FLAG_SLEEP_BIT = 2;
   localparam int FLAG_BUSY_BIT = 3;
   localparam int FLAG_PEND_BIT = 4;

   // Event bits in interrupt status and mask
   localparam int NUM_EV = 4;
   localparam int EV_SET_ALL = 0;
   localparam int EV_SLEEP = 1;
   localparam int EV_WAKE = 2;
   localparam int EV_ILLEGAL = 3;

   // Reset values
   localparam logic CTRL_EXT_RST = 1'b0;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic TMO_RST = 1'b1;
   localparam logic PDN_RST = 1'b1;
   localparam logic [15:0] INSTR_RST = 16'h0000;

   // Opcodes and data values
   localparam logic [6:0] SET_ALL_OPC = 7'h34;
   localparam logic [15:0] SLEEP_OPC = 16'h0003;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] LIT_OFS_MAX = 8'h5f;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

   // Quarter-phase divider: pclk cycles per quarter phase
   localparam int QDIV_DEF = 1;

   typedef enum logic [1:0] {SAE_Q1, SAE_Q2, SAE_Q3, SAE_Q4} sae_q_t;
   typedef enum logic [1:0] {SAE_IDLE, SAE_EXEC, SAE_SLEEP} sae_st_t;

   // Data-memory request
   typedef struct packed {
      logic [11:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
      logic indexed;
   } sae_mem_req_t;

   // Operand fields of a byte-oriented instruction
   typedef struct packed {
      logic a;
      logic [7:0] f;
   } sae_opnd_t;
endpackage

// ===== hw/sae_qgen.sv
// Quarter-phase generator: splits the instruction cycle into four phases.
// Assumes run is low while the oscillator is halted; phases then freeze.
module sae_qgen #(
   parameter int QDIV = sae_pkg::QDIV_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   output sae_pkg::sae_q_t q_phase,
   output logic q_tick
);
   typedef struct packed {
      logic [7:0] cnt;
      sae_pkg::sae_q_t ph;
   } sae_qs_t;

   sae_qs_t s_q, s_d;
   logic last;

   // Tick on the final pclk cycle of each quarter
   assign last = (s_q.cnt == 8'(QDIV - 1));
   assign q_tick = run & last;
   assign q_phase = s_q.ph;

   // Divider and phase advance
   always_comb begin
      s_d = s_q;
      if (run) begin
         s_d.cnt = last ? 8'h00 : s_q.cnt + 8'h01;
         if (last) begin
            s_d.ph = sae_pkg::sae_q_t'(s_q.ph + 2'h1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{cnt: 8'h00, ph: sae_pkg::SAE_Q1};
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ===== test/sae_exec_assertions.sv
// Checker for the set-all / sleep execution block, bound to its top ports.
// Assumes QDIV of 1, so each quarter phase lasts one pclk.
module sae_exec_assertions #(
   parameter int QDIV = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [11:0] index_base,
   input wire logic wake_req,
   input wire logic wake_by_wdt,
   input sae_pkg::sae_mem_req_t mem_req,
   input wire logic wdt_clr,
   input wire logic osc_run,
   input wire logic timeout_flag,
   input wire logic powerdown_flag,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Entry to and exit from the halted state
   sequence s_sleep_go;
      $fell(osc_run);
   endsequence
   sequence s_wake;
      !osc_run && wake_req;
   endsequence
   a_set_ones: assert property (mem_req.wr |-> mem_req.wdata == 8'hff)
      else $error("set-all wrote other than all ones");
   a_sleep_pd: assert property (s_sleep_go |-> !powerdown_flag)
      else $error("power-down flag not cleared by sleep");
   a_sleep_to: assert property (s_sleep_go |-> timeout_flag)
      else $error("time-out flag not set by sleep");
   a_sleep_wdt: assert property (s_sleep_go |-> wdt_clr)
      else $error("watchdog not cleared on sleep");
   a_sleep_noread: assert property (s_sleep_go |-> !$past(mem_req.rd, 2))
      else $error("operand read during sleep");
   a_asleep_hold: assert property (!osc_run && !wake_req |=> !osc_run)
      else $error("oscillator restarted without wake");
   a_rd_then_wr: assert property (mem_req.rd |-> ##2 mem_req.wr)
      else $error("write not two phases after read");
   a_wr_single: assert property (mem_req.wr |=> !mem_req.wr)
      else $error("write pulse longer than one phase");
   a_wake_wdt: assert property (s_wake and wake_by_wdt |=> osc_run && !timeout_flag)
      else $error("watchdog wake left time-out set");
   a_wake_keep: assert property (s_wake and !wake_by_wdt |=> osc_run && timeout_flag)
      else $error("plain wake changed time-out");
endmodule
bind sae_exec sae_exec_assertions #(.QDIV(QDIV)) u_sae_exec_assertions (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .index_base(index_base), .wake_req(wake_req),
   .wake_by_wdt(wake_by_wdt), .mem_req(mem_req), .wdt_clr(wdt_clr), .osc_run(osc_run),
   .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq));

// ===== test/sae_exec_bench.sv
// Bench for sae_exec: APB tasks, set-all address table, sleep, wake, bad opcode.
// Assumes a zero-wait APB slave; memory and watchdog are only watched.
module sae_exec_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, wake_req, wake_by_wdt;
   logic pready, pslverr, wdt_clr, osc_run, timeout_flag, powerdown_flag, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [11:0] index_base;
   sae_pkg::sae_mem_req_t mem_req, last;
   int fails, n_checks, nwr, nrd, nwdt, cyc, n;
   logic [8:0] opa [5] = '{9'h13c, 9'h020, 9'h080, 9'h05f, 9'h060};
   logic ext [5] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
   logic [12:0] exp_a [5] = '{13'h053c, 13'h0020, 13'h0f80, 13'h125f, 13'h0f60};

   sae_exec #(.QDIV(1)) u_sae_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .index_base(index_base), .wake_req(wake_req), .wake_by_wdt(wake_by_wdt),
      .mem_req(mem_req), .wdt_clr(wdt_clr), .osc_run(osc_run), .timeout_flag(timeout_flag),
      .powerdown_flag(powerdown_flag), .irq(irq));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      if (fails == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // One APB transfer; a fresh edge first, so strobes never change twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // Words written while busy are dropped, so poll until idle first
   task automatic issue(input logic [15:0] w);
      do apb(1'h0, sae_pkg::FLAGS_OFS, 32'h0); while (r[4:3] !== 2'h0);
      apb(1'h1, sae_pkg::INSTR_OFS, {16'h0, w});
   endtask

   task automatic sleep_wake(input logic wdt);
      n = nwdt;
      issue(sae_pkg::SLEEP_OPC);
      wait (osc_run === 1'h0);
      chk({30'h0, timeout_flag, powerdown_flag}, 32'h2);
      apb(1'h0, sae_pkg::FLAGS_OFS, 32'h0);
      chk(r & 32'h7, 32'h5);
      chk(nwdt - n, 32'h1);
      chk(nrd, 32'h5);
      wake_req <= 1'h1;
      wake_by_wdt <= wdt;
      @(posedge pclk);
      wake_req <= 1'h0;
      wait (osc_run === 1'h1);
      chk({31'h0, timeout_flag}, {31'h0, !wdt});
   endtask

   initial begin
      pclk = 1'h0;
      forever #12.5 pclk = ~pclk;
   end

   // Event counters and the hang limit
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (mem_req.wr === 1'h1) begin
         last <= mem_req;
         nwr <= nwr + 1;
      end
      if (mem_req.rd === 1'h1) nrd <= nrd + 1;
      if (wdt_clr === 1'h1) nwdt <= nwdt + 1;
      if (cyc == 5000) begin
         fails++;
         give_verdict();
      end
   end

   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wake_req = 1'h0;
      wake_by_wdt = 1'h0;
      index_base = 12'h200;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, sae_pkg::FLAGS_OFS, 32'h0);
      chk(r, 32'h3);
      apb(1'h0, 8'h18, 32'h0);
      chk({err, r[30:0]}, 32'h80000000);
      apb(1'h1, sae_pkg::BANK_OFS, 32'h5);
      apb(1'h1, sae_pkg::IMASK_OFS, 32'h1);
      for (int i = 0; i < 5; i++) begin
         apb(1'h1, sae_pkg::CTRL_OFS, {31'h0, ext[i]});
         n = nwr;
         issue({sae_pkg::SET_ALL_OPC, opa[i]});
         wait (nwr != n);
         chk({19'h0, last.indexed, last.addr}, {19'h0, exp_a[i]});
         chk({24'h0, last.wdata}, 32'hff);
      end
      chk(nrd, 32'h5);
      issue(16'h0000);
      // A write's setup also loads prdata, so read the flags afresh
      apb(1'h0, sae_pkg::FLAGS_OFS, 32'h0);
      chk(r & 32'h7, 32'h3);
      chk({31'h0, irq}, 32'h1);
      apb(1'h1, sae_pkg::ISTAT_OFS, 32'hf);
      // Clear lands at the access edge; look once it has settled
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
      sleep_wake(1'h1);
      sleep_wake(1'h0);
      // Drop the sleep events so only the near-miss word can show
      apb(1'h1, sae_pkg::ISTAT_OFS, 32'hf);
      issue(16'h0013);
      issue(16'h0000);
      apb(1'h0, sae_pkg::ISTAT_OFS, 32'h0);
      chk(r & 32'ha, 32'h8);
      chk({31'h0, osc_run}, 32'h1);
      give_verdict();
   end
endmodule
